// ==== pam_pkg.sv ====
// constants, register map and state encoding of the period averaging unit
package pam_pkg;

    // ********************************
    // clock and timing
    // ********************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned TO_UNIT_US = 10_000;
    localparam int unsigned TO_TICK_CYCLES = CLK_PER_US * TO_UNIT_US;
    localparam int unsigned FREQ_SCALE = CLK_HZ / 1_000;

    // ********************************
    // input ranges, maximum frequency in kHz
    // ********************************
    localparam int unsigned RANGE1_KHZ = 8;
    localparam int unsigned RANGE2_KHZ = 20;
    localparam int unsigned RANGE3_KHZ = 50;
    localparam int unsigned RANGE4_KHZ = 200;
    // edges closer than half the shortest period are rejected
    localparam logic [15:0] GAP1_CYC = 16'(CLK_HZ / (2 * 1000 * RANGE1_KHZ));
    localparam logic [15:0] GAP2_CYC = 16'(CLK_HZ / (2 * 1000 * RANGE2_KHZ));
    localparam logic [15:0] GAP3_CYC = 16'(CLK_HZ / (2 * 1000 * RANGE3_KHZ));
    localparam logic [15:0] GAP4_CYC = 16'(CLK_HZ / (2 * 1000 * RANGE4_KHZ));

    // ********************************
    // result format: signed, 8 fraction bits
    // ********************************
    localparam int unsigned FRAC_BITS = 8;
    localparam int ERR_RAW = -99999;
    localparam logic [31:0] ERR_RESULT = 32'(ERR_RAW * (1 << FRAC_BITS));
    localparam int unsigned MULT_FRAC = 16;
    localparam int unsigned MEM_DEPTH = 16;

    // ********************************
    // register map, byte addresses
    // ********************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_CYCLES = 8'h08;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h0C;
    localparam logic [7:0] ADDR_MULT = 8'h10;
    localparam logic [7:0] ADDR_OFFSET = 8'h14;
    localparam logic [7:0] ADDR_DEST = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [1:0] RESULT_PAGE = 2'h1;

    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CFG_REPS_LSB = 0;
    localparam int unsigned CFG_RANGE_LSB = 8;
    localparam int unsigned CFG_OPT_BIT = 12;
    localparam int unsigned CFG_CHAN_LSB = 16;
    localparam int unsigned STAT_BUSY = 0;
    localparam int unsigned STAT_DONE = 1;
    localparam int unsigned STAT_TOERR = 2;

    localparam logic [31:0] CFG_RST = 32'h0000_0401;
    localparam logic [15:0] CYCLES_RST = 16'h0001;
    localparam logic [15:0] TIMEOUT_RST = 16'h0064;
    localparam logic [31:0] MULT_RST = 32'h0001_0000;
    localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
    localparam logic [3:0] DEST_RST = 4'h0;

    typedef enum logic [2:0] {
        PAM_IDLE = 3'b000,
        PAM_WAIT_FIRST = 3'b001,
        PAM_COUNT = 3'b010,
        PAM_DIVIDE = 3'b011,
        PAM_SCALE = 3'b100
    } pam_state_t;

endpackage

// ==== pam_tick_gen.sv ====
// divider making one-cycle enable pulses at the time-out unit
`timescale 1ns/1ns
module pam_tick_gen #(
    parameter int unsigned PERIOD = 100000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    output logic tick
);
    localparam int unsigned CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic tick_nxt;

    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r + CW'(1);
        if (clear) begin
            cnt_nxt = '0;
        end else if (cnt_r == LAST) begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule

// ==== pam_seq_div.sv ====
// restoring divider, one quotient bit per clock
`timescale 1ns/1ns
module pam_seq_div #(
    parameter int unsigned NW = 48,
    parameter int unsigned DW = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [NW-1:0] dividend,
    input wire logic [DW-1:0] divisor,
    output logic done,
    output logic [NW-1:0] quotient
);
    localparam int unsigned KW = $clog2(NW + 1);

    logic [DW:0] rem_r;
    logic [DW:0] rem_nxt;
    logic [NW-1:0] quo_nxt;
    logic [DW-1:0] dvs_r;
    logic [DW-1:0] dvs_nxt;
    logic [KW-1:0] cnt_r;
    logic [KW-1:0] cnt_nxt;
    logic done_nxt;
    logic [DW:0] trial;

    always_comb begin
        rem_nxt = rem_r;
        quo_nxt = quotient;
        dvs_nxt = dvs_r;
        cnt_nxt = cnt_r;
        done_nxt = 1'b0;
        trial = {rem_r[DW-1:0], quotient[NW-1]};
        if (start) begin
            rem_nxt = '0;
            quo_nxt = dividend;
            dvs_nxt = divisor;
            cnt_nxt = KW'(NW);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - KW'(1);
            done_nxt = (cnt_r == KW'(1));
            if (trial >= {1'b0, dvs_r}) begin
                rem_nxt = trial - {1'b0, dvs_r};
                quo_nxt = {quotient[NW-2:0], 1'b1};
            end else begin
                rem_nxt = trial;
                quo_nxt = {quotient[NW-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_r <= '0;
            quotient <= '0;
            dvs_r <= '0;
            cnt_r <= '0;
            done <= 1'b0;
        end else begin
            rem_r <= rem_nxt;
            quotient <= quo_nxt;
            dvs_r <= dvs_nxt;
            cnt_r <= cnt_nxt;
            done <= done_nxt;
        end
    end
endmodule

// ==== pam_top.sv ====
// period averaging measurement unit with an APB register slave
//
// Behaviour
// - option 0 reports average period over the programmed cycles, in microseconds
// - option 1 reports frequency in kHz; range code selects input range
// - range codes 1..4 accept up to 8, 20, 50, 200 kHz
// - time-out value counts units of 0.01 second
// - each repetition waits at most the time-out, restarted per repetition
// - time-out expiry stores -99999 at the destination instead of a result
// - measurement ends as soon as the cycle count is reached
`timescale 1ns/1ns
module pam_top
    import pam_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = pam_pkg::TO_TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] sense_in,
    output logic meas_busy
);
    import pam_pkg::*;

    // ********************************
    // registers and state
    // ********************************
    logic [31:0] cfg_r, cfg_nxt, mult_r, mult_nxt, offs_r, offs_nxt;
    logic [15:0] cyc_r, cyc_nxt, to_r, to_nxt;
    logic [3:0] dest_r, dest_nxt;
    logic done_r, done_nxt, toerr_r, toerr_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    logic [31:0] mem [MEM_DEPTH];
    pam_state_t state_r, state_nxt;
    logic [7:0] rep_r, rep_nxt;
    logic [15:0] edge_r, edge_nxt, gap_r, gap_nxt, to_cnt_r, to_cnt_nxt;
    logic [31:0] per_r, per_nxt;
    logic prev_r, busy_nxt;
    logic mem_we;
    logic [3:0] mem_wa;
    logic [31:0] mem_wd;
    logic tick, tick_clear, div_start, div_done;
    logic [47:0] div_num, quo;
    logic [31:0] div_den, elapsed, scaled;
    logic [64:0] prod;
    logic fin, begin_rep, wr_en, start, rise, edge_ok, expired, bad_addr;
    logic [15:0] min_gap, target;
    logic [7:0] reps_eff;
    logic [2:0] range;
    logic opt_freq, sel_in;

    assign range = cfg_r[CFG_RANGE_LSB +: 3];
    assign opt_freq = cfg_r[CFG_OPT_BIT];
    assign sel_in = sense_in[cfg_r[CFG_CHAN_LSB +: 4]];
    assign target = (cyc_r == 16'h0000) ? 16'h0001 : cyc_r;
    assign reps_eff = (cfg_r[CFG_REPS_LSB +: 8] == 8'h00) ? 8'h01 : cfg_r[CFG_REPS_LSB +: 8];
    assign elapsed = per_r + 32'h0000_0001;

    pam_tick_gen #(.PERIOD(TICK_CYCLES)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .clear(tick_clear),
        .tick(tick)
    );

    pam_seq_div #(.NW(48), .DW(32)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start),
        .dividend(div_num),
        .divisor(div_den),
        .done(div_done),
        .quotient(quo)
    );

    // ********************************
    // input edge acceptance
    // ********************************
    // range sets minimum spacing
    always_comb begin
        unique case (range)
            3'h1: min_gap = GAP1_CYC;
            3'h2: min_gap = GAP2_CYC;
            3'h3: min_gap = GAP3_CYC;
            default: min_gap = GAP4_CYC;
        endcase
    end
    assign rise = sel_in & ~prev_r;
    assign edge_ok = rise & (gap_r >= min_gap);
    assign expired = (to_cnt_r >= to_r);

    // ********************************
    // result arithmetic
    // ********************************
    // period: clocks*256 / (clocks per us * cycles)
    always_comb begin
        if (opt_freq) begin
            div_num = 48'(target) * 48'(FREQ_SCALE) * 48'(1 << FRAC_BITS);
            div_den = elapsed;
        end else begin
            div_num = {8'h00, elapsed, 8'h00};
            div_den = 32'(target) * 32'(CLK_PER_US);
        end
    end
    assign prod = $signed({1'b0, quo[31:0]}) * $signed(mult_r);
    assign scaled = prod[MULT_FRAC +: 32] + offs_r;

    // ********************************
    // measurement sequencer
    // ********************************
    always_comb begin
        state_nxt = state_r;
        rep_nxt = rep_r;
        edge_nxt = edge_r;
        per_nxt = per_r;
        to_cnt_nxt = to_cnt_r;
        gap_nxt = (gap_r == 16'hFFFF) ? gap_r : gap_r + 16'h0001;
        mem_we = 1'b0;
        mem_wa = dest_r + rep_r[3:0];
        mem_wd = 32'h0000_0000;
        div_start = 1'b0;
        tick_clear = 1'b0;
        fin = 1'b0;
        begin_rep = 1'b0;
        if (edge_ok) begin
            gap_nxt = 16'h0000;
        end
        if (tick) begin
            to_cnt_nxt = to_cnt_r + 16'h0001;
        end
        unique case (state_r)
            PAM_IDLE: begin
                if (start) begin
                    rep_nxt = 8'h00;
                    begin_rep = 1'b1;
                end
            end
            PAM_WAIT_FIRST: begin
                if (expired) begin
                    mem_we = 1'b1;
                    mem_wd = ERR_RESULT;
                    fin = 1'b1;
                end else if (edge_ok) begin
                    per_nxt = 32'h0000_0000;
                    state_nxt = PAM_COUNT;
                end
            end
            PAM_COUNT: begin
                per_nxt = per_r + 32'h0000_0001;
                // finish on last cycle, not on time-out
                if (edge_ok && (edge_r + 16'h0001 == target)) begin
                    div_start = 1'b1;
                    state_nxt = PAM_DIVIDE;
                end else if (expired) begin
                    mem_we = 1'b1;
                    mem_wd = ERR_RESULT;
                    fin = 1'b1;
                end else if (edge_ok) begin
                    edge_nxt = edge_r + 16'h0001;
                end
            end
            PAM_DIVIDE: begin
                per_nxt = per_r;
                if (div_done) begin
                    state_nxt = PAM_SCALE;
                end
            end
            PAM_SCALE: begin
                mem_we = 1'b1;
                mem_wd = scaled;
                fin = 1'b1;
            end
            default: begin
                state_nxt = PAM_IDLE;
            end
        endcase
        if (fin) begin
            if (rep_r + 8'h01 >= reps_eff) begin
                state_nxt = PAM_IDLE;
            end else begin
                rep_nxt = rep_r + 8'h01;
                begin_rep = 1'b1;
            end
        end
        if (begin_rep) begin
            state_nxt = PAM_WAIT_FIRST;
            to_cnt_nxt = 16'h0000;
            tick_clear = 1'b1;
            gap_nxt = 16'hFFFF;
            edge_nxt = 16'h0000;
            per_nxt = 32'h0000_0000;
        end
        busy_nxt = (state_nxt != PAM_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= PAM_IDLE;
            rep_r <= 8'h00;
            edge_r <= 16'h0000;
            per_r <= 32'h0000_0000;
            to_cnt_r <= 16'h0000;
            gap_r <= 16'hFFFF;
            prev_r <= 1'b0;
            meas_busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rep_r <= rep_nxt;
            edge_r <= edge_nxt;
            per_r <= per_nxt;
            to_cnt_r <= to_cnt_nxt;
            gap_r <= gap_nxt;
            prev_r <= sel_in;
            meas_busy <= busy_nxt;
        end
    end

    // results keep no reset: software reads only what a run wrote
    always_ff @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ********************************
    // APB slave, zero wait states
    // ********************************
    assign bad_addr = (paddr[1:0] != 2'h0) ||
                      ((paddr[7:6] != RESULT_PAGE) && (paddr > ADDR_STATUS));
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;
    assign start = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_START] && (state_r == PAM_IDLE);

    always_comb begin
        cfg_nxt = cfg_r;
        cyc_nxt = cyc_r;
        to_nxt = to_r;
        mult_nxt = mult_r;
        offs_nxt = offs_r;
        dest_nxt = dest_r;
        done_nxt = done_r;
        toerr_nxt = toerr_r;
        if (wr_en) begin
            unique case (paddr)
                ADDR_CFG: cfg_nxt = pwdata & 32'h000F_17FF;
                ADDR_CYCLES: cyc_nxt = pwdata[15:0];
                ADDR_TIMEOUT: to_nxt = pwdata[15:0];
                ADDR_MULT: mult_nxt = pwdata;
                ADDR_OFFSET: offs_nxt = pwdata;
                ADDR_DEST: dest_nxt = pwdata[3:0];
                ADDR_STATUS: begin
                    done_nxt = done_r & ~pwdata[STAT_DONE];
                    toerr_nxt = toerr_r & ~pwdata[STAT_TOERR];
                end
                default: begin
                end
            endcase
        end
        // hardware set wins over a clear in the same cycle
        if (fin && (state_nxt == PAM_IDLE)) begin
            done_nxt = 1'b1;
        end
        if (fin && (state_r != PAM_SCALE)) begin
            toerr_nxt = 1'b1;
        end
        pready_nxt = psel & ~penable;
        pslverr_nxt = psel & ~penable & bad_addr;
        prdata_nxt = 32'h0000_0000;
        if (psel && !penable && !bad_addr && !pwrite) begin
            if (paddr[7:6] == RESULT_PAGE) begin
                prdata_nxt = mem[paddr[5:2]];
            end else begin
                unique case (paddr)
                    ADDR_CFG: prdata_nxt = cfg_r;
                    ADDR_CYCLES: prdata_nxt = {16'h0000, cyc_r};
                    ADDR_TIMEOUT: prdata_nxt = {16'h0000, to_r};
                    ADDR_MULT: prdata_nxt = mult_r;
                    ADDR_OFFSET: prdata_nxt = offs_r;
                    ADDR_DEST: prdata_nxt = {28'h0000000, dest_r};
                    ADDR_STATUS: prdata_nxt = {29'h0000000, toerr_r, done_r, meas_busy};
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RST;
            cyc_r <= CYCLES_RST;
            to_r <= TIMEOUT_RST;
            mult_r <= MULT_RST;
            offs_r <= OFFSET_RST;
            dest_r <= DEST_RST;
            done_r <= 1'b0;
            toerr_r <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            cyc_r <= cyc_nxt;
            to_r <= to_nxt;
            mult_r <= mult_nxt;
            offs_r <= offs_nxt;
            dest_r <= dest_nxt;
            done_r <= done_nxt;
            toerr_r <= toerr_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_period_div;
        div_start && !opt_freq |-> div_den == 32'(target) * 32'(CLK_PER_US) && div_num[15:8] == elapsed[7:0];
    endproperty
    a_period_div: assert property (p_period_div) else $error("period divisor wrong");
    property p_freq_div;
        div_start && opt_freq |-> div_den == elapsed && div_num == 48'(target) * 48'd2560000;
    endproperty
    a_freq_div: assert property (p_freq_div) else $error("frequency dividend wrong");
    property p_gap;
        state_r == PAM_COUNT && edge_ok && !expired |=> edge_r == $past(edge_r) + 16'h0001 || state_r == PAM_DIVIDE;
    endproperty
    a_gap: assert property (p_gap) else $error("accepted edge not counted");
    property p_close_edge;
        rise && gap_r < min_gap && state_r == PAM_COUNT && !expired |=> edge_r == $past(edge_r);
    endproperty
    a_close_edge: assert property (p_close_edge) else $error("too fast edge counted");
    property p_tick_count;
        (state_r == PAM_COUNT) && tick && !fin && !div_start |=> to_cnt_r == $past(to_cnt_r) + 16'h0001;
    endproperty
    a_tick_count: assert property (p_tick_count) else $error("time-out unit not counted");
    property p_restart;
        fin && state_nxt == PAM_WAIT_FIRST |=> to_cnt_r == 16'h0000 && edge_r == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("time-out not restarted");
    property p_err_store;
        (state_r == PAM_WAIT_FIRST || state_r == PAM_COUNT) && expired && !div_start
            |-> mem_we && mem_wd == ERR_RESULT ##1 toerr_r;
    endproperty
    a_err_store: assert property (p_err_store) else $error("error value not stored");
    property p_early_done;
        div_start |=> state_r == PAM_DIVIDE ##[1:60] state_r == PAM_SCALE;
    endproperty
    a_early_done: assert property (p_early_done) else $error("finish not prompt");
    property p_scale;
        state_r == PAM_SCALE |-> mem_we && mem_wd == prod[47:16] + offs_r;
    endproperty
    a_scale: assert property (p_scale) else $error("scaled result not stored");
    property p_apb_ready;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("pready not single cycle");

    c_timeout: cover property (state_r == PAM_COUNT && expired);
    c_freq_done: cover property (state_r == PAM_SCALE && opt_freq);
    c_multi_rep: cover property (fin && state_nxt == PAM_WAIT_FIRST);
    c_period_done: cover property (state_r == PAM_SCALE && !opt_freq);
endmodule

// ==== pam_sensor_model.sv ====
// behavioural frequency-output resonator feeding one sensor channel
`timescale 1ns/1ns
module pam_sensor_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [3:0] chan,
    input wire logic [15:0] half_cyc,
    output logic [15:0] sense_in
);
    logic [15:0] cnt_r;
    logic wave_r;
    logic noise_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            wave_r <= 1'b0;
            noise_r <= 1'b0;
        end else begin
            noise_r <= ~noise_r;
            if (!run) begin
                cnt_r <= 16'h0000;
                wave_r <= 1'b0;
            end else if (cnt_r >= half_cyc - 16'h0001) begin
                cnt_r <= 16'h0000;
                wave_r <= ~wave_r;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end
    // unselected channels toggle every cycle, so a wrong channel shows up
    always_comb begin
        sense_in = {16{noise_r}};
        sense_in[chan] = wave_r;
    end
endmodule

// ==== pam_top_tb.sv ====
// self-checking testbench of the period averaging unit
`timescale 1ns/1ns
module pam_top_tb;
    import pam_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] sense_in;
    logic meas_busy;
    logic run = 1'b0;
    logic [15:0] half_cyc = 16'h0019;
    int errors = 0;
    int samples_checked = 0;
    always #50 pclk = ~pclk;
    pam_top #(.TICK_CYCLES(20)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sense_in(sense_in), .meas_busy(meas_busy));
    pam_sensor_model i_sensor (.pclk(pclk), .presetn(presetn), .run(run), .chan(4'h3),
        .half_cyc(half_cyc), .sense_in(sense_in));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ********************************
    // apb master, one transfer
    // ********************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            complete_run();
        end
        // idle edge, so a following setup never reassigns psel in this step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    function automatic logic [31:0] mkcfg(input logic opt, input logic [2:0] rng, input logic [7:0] reps);
        return {12'h000, 4'h3, 3'b000, opt, 1'b0, rng, reps};
    endfunction

    // programs one run, starts it and counts clocks until busy drops
    task automatic measure(input logic [31:0] cfg, input logic [15:0] to, input logic [31:0] mult,
                           input logic [31:0] off, input logic [3:0] dest, output int cyc);
        wr(ADDR_CFG, cfg);
        wr(ADDR_CYCLES, 32'h0000_0004);
        wr(ADDR_TIMEOUT, {16'h0000, to});
        wr(ADDR_MULT, mult);
        wr(ADDR_OFFSET, off);
        wr(ADDR_DEST, {28'h0000000, dest});
        wr(ADDR_STATUS, 32'h0000_0006);
        wr(ADDR_CTRL, 32'h0000_0001);
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (meas_busy !== 1'b0 && cyc < 5000);
        if (meas_busy !== 1'b0) begin
            errors++;
            complete_run();
        end
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic e;
        rd_chk(ADDR_CFG, CFG_RST);
        rd_chk(ADDR_TIMEOUT, {16'h0000, TIMEOUT_RST});
        rd_chk(ADDR_MULT, MULT_RST);
        apb(1'b0, 8'h20, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
    endtask

    // 4 cycles of 50 clocks: 5 us average period, well before time-out
    task automatic t_period();
        int cyc;
        run <= 1'b1;
        measure(mkcfg(1'b0, 3'h4, 8'h01), 16'h0064, 32'h0001_0000, 32'h0, 4'h2, cyc);
        rd_chk(8'h48, 32'h0000_0500);
        chk(32'(cyc < 400), 32'h1);
        rd_chk(ADDR_STATUS, 32'h0000_0002);
        $display("test period done");
    endtask

    // 200 kHz times 2.0 plus 1.0
    task automatic t_freq();
        int cyc;
        measure(mkcfg(1'b1, 3'h4, 8'h01), 16'h0064, 32'h0002_0000, 32'h0000_0100, 4'h5, cyc);
        rd_chk(8'h54, 32'h0001_9100);
        $display("test freq done");
    endtask

    // silent sensor, two reps wrapping past slot 15
    task automatic t_timeout();
        int cyc;
        run <= 1'b0;
        measure(mkcfg(1'b0, 3'h4, 8'h02), 16'h0002, 32'h0001_0000, 32'h0, 4'hF, cyc);
        rd_chk(8'h7C, ERR_RESULT);
        rd_chk(8'h40, ERR_RESULT);
        chk(32'(cyc >= 80 && cyc <= 100), 32'h1);
        rd_chk(ADDR_STATUS, 32'h0000_0006);
        $display("test timeout done");
    endtask

    // 200 kHz input exceeds ranges 1..3, so edges are refused
    task automatic t_range();
        int cyc;
        run <= 1'b1;
        for (int r = 1; r <= 3; r++) begin
            measure(mkcfg(1'b0, 3'(r), 8'h01), 16'h0005, 32'h0001_0000, 32'h0, 4'h7, cyc);
            rd_chk(8'h5C, ERR_RESULT);
            rd_chk(ADDR_STATUS, 32'h0000_0006);
        end
        $display("test range done");
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_period();
        t_freq();
        t_timeout();
        t_range();
        complete_run();
    end
endmodule
